//--- src/cgp_consts.svh
// Constants for the clock generator protection and standby control block
`ifndef CGP_CONSTS_SVH
`define CGP_CONSTS_SVH

`define CGP_ADDR_W 32
`define CGP_ADDR_LOCK 32'hFFFF_F824
`define CGP_ADDR_CLKCTL 32'hFFFF_F822
`define CGP_ADDR_PROTSTAT 32'hFFFF_F802
`define CGP_ADDR_PROTCMD 32'hFFFF_F800
`define CGP_ADDR_STBKIND 32'hFFFF_F820
`define CGP_ADDR_STBCTL 32'hFFFF_F1FE
`define CGP_PERIPH_BASE 32'hFFFF_F000
`define CGP_CLKCTL_RST 8'h00
`define CGP_STBCTL_RST 8'h00
`define CGP_BIT_PROTECT_ERROR_FLAG 0
`define CGP_BIT_LOCK 0
`define CGP_BIT_STBKIND 0
`define CGP_BIT_STB 1
`define CGP_BIT_INTM 4
`define CGP_BIT_NMIM 5
`define CGP_MUL_MSB 2
`define CGP_MUL_X1 3'h0
`define CGP_MUL_X2P5 3'h1
`define CGP_MUL_X5 3'h3
`define CGP_MUL_X10 3'h7
`define CGP_MUL_FIELD_MASK 8'h07
`define CGP_STBCTL_MASK 8'h32

`endif

//--- src/cgp_pkg.sv
// Types for the clock generator protection and standby control block
package cgp_pkg;
  typedef enum logic [3:0] {
    CGP_RUN = 4'h1,
    CGP_HALT = 4'h2,
    CGP_IDLE = 4'h4,
    CGP_STOP = 4'h8
  } cgp_mode_e;

  typedef struct packed {
    logic cmd_armed;
    logic prot_err;
    logic [7:0] clk_ctl;
    logic stb_kind;
    logic [7:0] stb_ctl;
    logic lock_flag;
    cgp_mode_e mode;
    logic [7:0] rdata;
    logic cpu_clk_en;
    logic sys_clk_en;
    logic osc_stop;
    logic [2:0] pll_mul;
    logic direct_sel;
    logic mul_bad;
    logic [2:0] sel_sync;
    logic [2:0] pll_sync;
    logic [2:0] wake_sync;
  } cgp_state_s;
endpackage : cgp_pkg

//--- src/cgp_clock_ctl.sv
// Clock generator control: protected clock register, lock flag, HALT/IDLE/STOP
//
// Contract
// (R1) Clock control write counts only if the previous store hit the command register.
// (R2) Software masks interrupts around the protected sequence.
// (R3) Software runs five no-ops after the protected write.
// (R4) Interrupt between command and protected write discards the write, flags error.
// (R5) Protected registers read back without any unlock sequence.
// (R6) Command data is ignored; software reuses the same general register.
// (R7) Software finishes all DMA before the protected sequence.
// (R8) Unsequenced protected write is dropped and sets the sticky error flag.
// (R9) Protected write not preceded by a command write sets the error flag.
// (R10) First store after command write to ordinary memory sets the error flag.
// (R11) Error flag clears by writing zero or by reset; byte or bit access.
// (R12) Lock flag is bit 0, read only; zero locked, one unlocked.
// (R13) Lock flag not reset; upper seven bits read zero.
// (R14) Lock flag clears on lock, sets on standby loss, else unchanged.
// (R15) Lockup lasts from power-on or STOP release until phase lock.
// (R16) Software polls lock flag after unlock for timing-critical work.
// (R17) HALT keeps oscillator, PLL and peripheral clocks; CPU clock stops.
// (R18) HALT is entered by the halt instruction.
// (R19) IDLE keeps oscillator and PLL but stops all system clocks.
// (R20) IDLE release returns to normal at once, no stabilisation wait.
// (R21) IDLE is entered through the standby kind setting, not an instruction.
// (R22) PLL multiplier selects 1, 2.5, 5 or 10 times; other codes prohibited.
// (R23) Standby kind bit: zero selects IDLE, one selects STOP.
// (R24) Writing one to standby entry bit starts standby; cleared on release.
// (R25) Mode pin high selects direct half-rate clock, low selects PLL.
`timescale 1ns/10ps
`default_nettype none
`include "cgp_consts.svh"

module cgp_clock_ctl
  import cgp_pkg::*;
(
  input wire logic sys_clk,
  input wire logic nrst,
  input wire logic st_valid,
  input wire logic [`CGP_ADDR_W-1:0] st_addr,
  input wire logic [7:0] st_wdata,
  input wire logic [7:0] st_bmask,
  input wire logic st_is_periph,
  input wire logic rd_valid,
  input wire logic [`CGP_ADDR_W-1:0] rd_addr,
  input wire logic irq_ack,
  input wire logic halt_instr,
  input wire logic clock_mode_select_pin,
  input wire logic pll_phase_locked,
  input wire logic standby_release,
  output logic [7:0] rd_data,
  output logic prot_error,
  output logic cpu_clk_en,
  output logic sys_clk_en,
  output logic osc_stop,
  output logic [2:0] pll_mult_sel,
  output logic direct_mode,
  output logic mult_prohibited,
  output logic standby_active
);

  cgp_state_s s_reg;
  cgp_state_s s_next;

  logic pin_high;
  logic pll_lk;
  logic wake;
  logic hit_cmd;
  logic hit_clk;
  logic hit_err;
  logic hit_kind;
  logic hit_stb;
  logic hit_prot;
  logic ok_prot;
  logic bad_first;
  logic [7:0] wv;
  logic [7:0] old_err;

  always_comb begin
    s_next = s_reg;
    // Pins pass three flops; a mode pin change counts once the last two agree, lock and release need both high
    s_next.sel_sync = {s_reg.sel_sync[1:0], clock_mode_select_pin};
    s_next.pll_sync = {s_reg.pll_sync[1:0], pll_phase_locked};
    s_next.wake_sync = {s_reg.wake_sync[1:0], standby_release};
    pin_high = (s_reg.sel_sync[2] == s_reg.sel_sync[1]) ? s_reg.sel_sync[1] : s_reg.direct_sel;
    pll_lk = (s_reg.pll_sync[2] == s_reg.pll_sync[1]) && s_reg.pll_sync[1];
    wake = (s_reg.wake_sync[2] == s_reg.wake_sync[1]) && s_reg.wake_sync[1];

    hit_cmd = st_valid && (st_addr == `CGP_ADDR_PROTCMD);
    hit_clk = st_valid && (st_addr == `CGP_ADDR_CLKCTL);
    hit_stb = st_valid && (st_addr == `CGP_ADDR_STBCTL);
    hit_err = st_valid && (st_addr == `CGP_ADDR_PROTSTAT);
    hit_kind = st_valid && (st_addr == `CGP_ADDR_STBKIND);
    hit_prot = hit_clk || hit_stb;
    // (R1) Protected write allowed only right after the command write
    ok_prot = hit_prot && s_reg.cmd_armed && !irq_ack;
    // (R10) First store after command targets ordinary memory
    bad_first = st_valid && s_reg.cmd_armed && !st_is_periph && !hit_prot;

    // (R6) Command data ignored; arm on any command store
    if (st_valid) begin
      s_next.cmd_armed = hit_cmd;
    end
    // (R4) Interrupt in the gap disarms the sequence
    if (irq_ack && !st_valid) begin
      s_next.cmd_armed = 1'b0;
    end

    // (R11) Bit-mask write of the status byte; zero clears the error
    old_err = 8'h00;
    old_err[`CGP_BIT_PROTECT_ERROR_FLAG] = s_reg.prot_err;
    wv = (st_wdata & st_bmask) | (old_err & ~st_bmask);
    if (hit_err) begin
      s_next.prot_err = wv[`CGP_BIT_PROTECT_ERROR_FLAG];
    end
    // (R8) (R9) Error is sticky and wins over a clear in the same cycle
    if ((hit_prot && !ok_prot) || bad_first) begin
      s_next.prot_err = 1'b1;
    end

    // (R22) Multiplier field held in the protected register
    if (hit_clk && ok_prot) begin
      s_next.clk_ctl = (st_wdata & st_bmask) | (s_reg.clk_ctl & ~st_bmask);
    end
    // (R23) Standby kind selection
    if (hit_kind && st_bmask[`CGP_BIT_STBKIND]) begin
      s_next.stb_kind = st_wdata[`CGP_BIT_STBKIND];
    end
    if (hit_stb && ok_prot) begin
      s_next.stb_ctl = ((st_wdata & st_bmask) | (s_reg.stb_ctl & ~st_bmask)) & `CGP_STBCTL_MASK;
    end

    s_next.direct_sel = pin_high;
    // Field copy follows the accepted write at the same edge
    s_next.pll_mul = s_next.clk_ctl[`CGP_MUL_MSB:0];
    // (R22) (R25) Flag prohibited codes in PLL mode only
    s_next.mul_bad = !pin_high && !((s_next.clk_ctl[`CGP_MUL_MSB:0] == `CGP_MUL_X1)
      || (s_next.clk_ctl[`CGP_MUL_MSB:0] == `CGP_MUL_X2P5)
      || (s_next.clk_ctl[`CGP_MUL_MSB:0] == `CGP_MUL_X5)
      || (s_next.clk_ctl[`CGP_MUL_MSB:0] == `CGP_MUL_X10));

    // Power save sequencing
    case (s_reg.mode)
      CGP_RUN: begin
        // (R18) Halt instruction enters HALT
        if (halt_instr) begin
          s_next.mode = CGP_HALT;
        // (R21) (R24) Entry bit starts the selected standby
        end else if (s_reg.stb_ctl[`CGP_BIT_STB]) begin
          s_next.mode = s_reg.stb_kind ? CGP_STOP : CGP_IDLE;
        end
      end
      CGP_HALT: begin
        if (wake) begin
          s_next.mode = CGP_RUN;
        end
      end
      CGP_IDLE, CGP_STOP: begin
        // (R20) Release goes straight to normal operation
        // (R24) Hardware clears the entry bit on release
        if (wake) begin
          s_next.mode = CGP_RUN;
          s_next.stb_ctl[`CGP_BIT_STB] = 1'b0;
        end
      end
      default: begin
        s_next.mode = CGP_RUN;
      end
    endcase

    // (R17) (R19) Clock gating per mode; oscillator stops only in STOP
    s_next.cpu_clk_en = (s_next.mode == CGP_RUN);
    s_next.sys_clk_en = (s_next.mode == CGP_RUN) || (s_next.mode == CGP_HALT);
    s_next.osc_stop = (s_next.mode == CGP_STOP);

    // (R14) (R15) Lock clears on phase lock, sets on loss due to standby
    if (s_reg.mode == CGP_STOP) begin
      s_next.lock_flag = 1'b1;
    end else if (pll_lk) begin
      s_next.lock_flag = 1'b0;
    end

    // (R5) (R12) (R13) Plain reads; lock register upper bits zero
    s_next.rdata = 8'h00;
    if (rd_valid) begin
      case (rd_addr)
        `CGP_ADDR_LOCK: s_next.rdata[`CGP_BIT_LOCK] = s_reg.lock_flag;
        `CGP_ADDR_CLKCTL: s_next.rdata = s_reg.clk_ctl;
        `CGP_ADDR_PROTSTAT: s_next.rdata[`CGP_BIT_PROTECT_ERROR_FLAG] = s_reg.prot_err;
        `CGP_ADDR_STBKIND: s_next.rdata[`CGP_BIT_STBKIND] = s_reg.stb_kind;
        `CGP_ADDR_STBCTL: s_next.rdata = s_reg.stb_ctl;
        default: s_next.rdata = 8'h00;
      endcase
    end
  end

  // Lock flag has no reset branch; it only moves outside reset
  always_ff @(posedge sys_clk or negedge nrst) begin
    if (!nrst) begin
      s_reg.cmd_armed <= 1'b0;
      // (R11) Reset clears the error flag
      s_reg.prot_err <= 1'b0;
      s_reg.clk_ctl <= `CGP_CLKCTL_RST;
      s_reg.stb_kind <= 1'b0;
      s_reg.stb_ctl <= `CGP_STBCTL_RST;
      s_reg.mode <= CGP_RUN;
      s_reg.rdata <= 8'h00;
      s_reg.cpu_clk_en <= 1'b1;
      s_reg.sys_clk_en <= 1'b1;
      s_reg.osc_stop <= 1'b0;
      s_reg.pll_mul <= `CGP_MUL_X1;
      s_reg.direct_sel <= 1'b0;
      s_reg.mul_bad <= 1'b0;
      s_reg.sel_sync <= 3'h0;
      s_reg.pll_sync <= 3'h0;
      s_reg.wake_sync <= 3'h0;
    end else begin
      s_reg.cmd_armed <= s_next.cmd_armed;
      s_reg.lock_flag <= s_next.lock_flag;
      s_reg.prot_err <= s_next.prot_err;
      s_reg.clk_ctl <= s_next.clk_ctl;
      s_reg.stb_kind <= s_next.stb_kind;
      s_reg.stb_ctl <= s_next.stb_ctl;
      s_reg.mode <= s_next.mode;
      s_reg.rdata <= s_next.rdata;
      s_reg.cpu_clk_en <= s_next.cpu_clk_en;
      s_reg.sys_clk_en <= s_next.sys_clk_en;
      s_reg.osc_stop <= s_next.osc_stop;
      s_reg.pll_mul <= s_next.pll_mul;
      s_reg.direct_sel <= s_next.direct_sel;
      s_reg.mul_bad <= s_next.mul_bad;
      s_reg.sel_sync <= s_next.sel_sync;
      s_reg.pll_sync <= s_next.pll_sync;
      s_reg.wake_sync <= s_next.wake_sync;
    end
  end

  // (R25) Outputs straight from flops
  assign rd_data = s_reg.rdata;
  assign prot_error = s_reg.prot_err;
  assign cpu_clk_en = s_reg.cpu_clk_en;
  assign sys_clk_en = s_reg.sys_clk_en;
  assign osc_stop = s_reg.osc_stop;
  assign pll_mult_sel = s_reg.pll_mul;
  assign direct_mode = s_reg.direct_sel;
  assign mult_prohibited = s_reg.mul_bad;
  assign standby_active = s_reg.stb_ctl[`CGP_BIT_STB];

endmodule : cgp_clock_ctl
`default_nettype wire

//--- tb/cgp_clock_ctl_monitor.sv
// Concurrent checks on the clock block ports
`timescale 1ns/10ps
`default_nettype none
`include "cgp_consts.svh"
module cgp_clock_ctl_monitor (
  input wire logic sys_clk,
  input wire logic nrst,
  input wire logic st_valid,
  input wire logic [`CGP_ADDR_W-1:0] st_addr,
  input wire logic [7:0] st_wdata,
  input wire logic [7:0] st_bmask,
  input wire logic st_is_periph,
  input wire logic rd_valid,
  input wire logic [`CGP_ADDR_W-1:0] rd_addr,
  input wire logic irq_ack,
  input wire logic halt_instr,
  input wire logic [7:0] rd_data,
  input wire logic prot_error,
  input wire logic cpu_clk_en,
  input wire logic sys_clk_en,
  input wire logic [2:0] pll_mult_sel
);
  default clocking @(posedge sys_clk); endclocking
  default disable iff (!nrst);
  logic armed_reg;
  logic prot_st;
  logic ok_st;
  logic clr_st;
  assign prot_st = st_valid && (st_addr == `CGP_ADDR_CLKCTL || st_addr == `CGP_ADDR_STBCTL);
  assign ok_st = st_valid && armed_reg && !irq_ack;
  assign clr_st = st_valid && st_addr == `CGP_ADDR_PROTSTAT && st_bmask[0] && !st_wdata[0];
  // Command store seen, not yet spent by a store or an interrupt
  always_ff @(posedge sys_clk or negedge nrst) begin
    if (!nrst) begin
      armed_reg <= 1'h0;
    end else begin
      armed_reg <= st_valid ? st_addr == `CGP_ADDR_PROTCMD : armed_reg && !irq_ack;
    end
  end
  a_bad_store:
    assert property (prot_st && !ok_st |=> prot_error) else $error("flag not set");
  a_mem_after_cmd:
    assert property (ok_st && !st_is_periph |=> prot_error) else $error("flag not set");
  a_err_sticky:
    assert property (prot_error && !clr_st |=> prot_error) else $error("flag dropped");
  a_err_clear:
    assert property (clr_st && !armed_reg |=> !prot_error) else $error("flag not cleared");
  a_good_write:
    assert property (ok_st && st_addr == `CGP_ADDR_CLKCTL && st_bmask == 8'hFF
      |=> pll_mult_sel == $past(st_wdata[2:0])) else $error("write not applied");
  a_lock_upper:
    assert property (rd_valid && rd_addr == `CGP_ADDR_LOCK |=> rd_data[7:1] == 7'h00)
      else $error("lock upper bits set");
  a_read_back:
    assert property (rd_valid && rd_addr == `CGP_ADDR_CLKCTL && !st_valid
      |=> rd_data[2:0] == pll_mult_sel) else $error("bad read back");
  a_halt_cpu:
    assert property (halt_instr |=> !cpu_clk_en && sys_clk_en) else $error("bad halt clocks");
endmodule : cgp_clock_ctl_monitor
bind cgp_clock_ctl cgp_clock_ctl_monitor cgp_clock_ctl_monitor_i (.*);
`default_nettype wire

//--- tb/cgp_cpu.sv
// CPU side model issuing stores, reads and event pulses
`timescale 1ns/10ps
`default_nettype none
`include "cgp_consts.svh"
module cgp_cpu (
  input wire logic sys_clk,
  input wire logic [7:0] rd_data,
  output logic st_valid,
  output logic [`CGP_ADDR_W-1:0] st_addr,
  output logic [7:0] st_wdata,
  output logic [7:0] st_bmask,
  output logic st_is_periph,
  output logic rd_valid,
  output logic [`CGP_ADDR_W-1:0] rd_addr,
  output logic irq_ack,
  output logic halt_instr
);
  initial begin
    {st_valid, st_addr, st_wdata, st_bmask, st_is_periph} = '0;
    {rd_valid, rd_addr, irq_ack, halt_instr} = '0;
  end
  task automatic st(input logic [`CGP_ADDR_W-1:0] a, input logic [7:0] d, m, input logic p);
    @(posedge sys_clk);
    st_valid <= 1'h1;
    st_addr <= a;
    st_wdata <= d;
    st_bmask <= m;
    st_is_periph <= p;
    @(posedge sys_clk);
    st_valid <= 1'h0;
    st_addr <= ~a;
    st_wdata <= ~d;
    #1;
  endtask : st
  // command then target, same data, no interrupt taken
  // No DMA traffic exists in this model, so none is pending
  task automatic pst(input logic [`CGP_ADDR_W-1:0] a, input logic [7:0] d);
    st(`CGP_ADDR_PROTCMD, d, 8'hFF, 1'h1);
    st(a, d, 8'hFF, 1'h1);
    repeat (5) @(posedge sys_clk);
  endtask : pst
  task automatic rd(input logic [`CGP_ADDR_W-1:0] a, output logic [7:0] d);
    @(posedge sys_clk);
    rd_valid <= 1'h1;
    rd_addr <= a;
    @(posedge sys_clk);
    rd_valid <= 1'h0;
    rd_addr <= ~a;
    #1 d = rd_data;
  endtask : rd
  task automatic pulse(input logic h);
    @(posedge sys_clk);
    if (h) halt_instr <= 1'h1;
    else irq_ack <= 1'h1;
    @(posedge sys_clk);
    {halt_instr, irq_ack} <= 2'h0;
    #1;
  endtask : pulse
endmodule : cgp_cpu
`default_nettype wire

//--- tb/cgp_clock_ctl_tb.sv
// Testbench for the clock block
`timescale 1ns/10ps
`default_nettype none
`include "cgp_consts.svh"
module cgp_clock_ctl_tb;
  logic sys_clk, nrst, clock_mode_select_pin, pll_phase_locked, standby_release;
  logic st_valid, st_is_periph, rd_valid, irq_ack, halt_instr;
  logic [`CGP_ADDR_W-1:0] st_addr, rd_addr;
  logic [7:0] st_wdata, st_bmask, rd_data, d;
  logic prot_error, cpu_clk_en, sys_clk_en, osc_stop, direct_mode;
  logic mult_prohibited, standby_active;
  logic [2:0] pll_mult_sel;
  logic [2:0] muls [5] = '{`CGP_MUL_X1, `CGP_MUL_X2P5, `CGP_MUL_X5, `CGP_MUL_X10, 3'h2};
  int n_fail = 0;
  int n_checks = 0;
  cgp_clock_ctl cgp_clock_ctl_i (.*);
  cgp_cpu cgp_cpu_i (.*);
  initial begin
    sys_clk = 1'h0;
    forever #5 sys_clk = ~sys_clk;
  end
  task automatic chk(input logic [7:0] g, e);
    n_checks++;
    if (g !== e) begin
      n_fail++;
      $display("wrong value at %0t: got %h expected %h", $time, g, e);
    end
  endtask : chk
  task automatic summarize();
    $display("checks %0d failures %0d", n_checks, n_fail);
    if (n_fail == 0 && n_checks > 0) begin
      $display("Simulation passed");
    end else begin
      $display("Simulation failed");
    end
    $finish;
  endtask : summarize
  task automatic wake();
    int i;
    @(posedge sys_clk) standby_release <= 1'h1;
    for (i = 0; i < 20; i++) begin
      @(posedge sys_clk) #1;
      if (cpu_clk_en === 1'h1 && sys_clk_en === 1'h1) break;
    end
    @(posedge sys_clk) standby_release <= 1'h0;
    if (i == 20) begin
      n_fail++;
      summarize();
    end
  endtask : wake
  initial begin
    {nrst, clock_mode_select_pin, standby_release} = 3'h0;
    pll_phase_locked = 1'h1;
    repeat (8) @(posedge sys_clk);
    nrst <= 1'h1;
    repeat (6) @(posedge sys_clk);
    cgp_cpu_i.rd(`CGP_ADDR_LOCK, d);
    chk(d, 8'h00);
    foreach (muls[k]) begin
      cgp_cpu_i.pst(`CGP_ADDR_CLKCTL, {5'h00, muls[k]});
      cgp_cpu_i.rd(`CGP_ADDR_CLKCTL, d);
      chk(d[2:0], muls[k]);
      chk(mult_prohibited, k == 4);
    end
    cgp_cpu_i.st(`CGP_ADDR_CLKCTL, 8'h07, 8'hFF, 1'h1);
    chk({prot_error, pll_mult_sel}, 4'hA);
    cgp_cpu_i.st(`CGP_ADDR_STBKIND, 8'h00, 8'hFF, 1'h1);
    chk(prot_error, 1'h1);
    cgp_cpu_i.st(`CGP_ADDR_PROTSTAT, 8'h00, 8'h01, 1'h1);
    chk(prot_error, 1'h0);
    cgp_cpu_i.st(`CGP_ADDR_PROTCMD, 8'h07, 8'hFF, 1'h1);
    cgp_cpu_i.pulse(1'h0);
    cgp_cpu_i.st(`CGP_ADDR_CLKCTL, 8'h07, 8'hFF, 1'h1);
    chk({prot_error, pll_mult_sel}, 4'hA);
    cgp_cpu_i.st(`CGP_ADDR_PROTSTAT, 8'h00, 8'hFF, 1'h1);
    cgp_cpu_i.st(`CGP_ADDR_PROTCMD, 8'h00, 8'hFF, 1'h1);
    cgp_cpu_i.st(32'h0000_1000, 8'h00, 8'hFF, 1'h0);
    chk(prot_error, 1'h1);
    cgp_cpu_i.pulse(1'h1);
    chk({cpu_clk_en, sys_clk_en}, 2'h1);
    wake();
    cgp_cpu_i.pst(`CGP_ADDR_STBCTL, 8'h02);
    chk({cpu_clk_en, sys_clk_en, osc_stop, standby_active}, 4'h1);
    wake();
    chk(standby_active, 1'h0);
    cgp_cpu_i.st(`CGP_ADDR_STBKIND, 8'h01, 8'hFF, 1'h1);
    cgp_cpu_i.pst(`CGP_ADDR_STBCTL, 8'h02);
    chk({sys_clk_en, osc_stop}, 2'h1);
    @(posedge sys_clk) pll_phase_locked <= 1'h0;
    wake();
    cgp_cpu_i.rd(`CGP_ADDR_LOCK, d);
    chk(d, 8'h01);
    @(posedge sys_clk) pll_phase_locked <= 1'h1;
    repeat (6) @(posedge sys_clk);
    // Poll lock flag until it shows lock
    for (int p = 0; p < 20 && d !== 8'h00; p++) cgp_cpu_i.rd(`CGP_ADDR_LOCK, d);
    cgp_cpu_i.rd(`CGP_ADDR_LOCK, d);
    chk(d, 8'h00);
    @(posedge sys_clk) clock_mode_select_pin <= 1'h1;
    repeat (6) @(posedge sys_clk);
    #1 chk({direct_mode, mult_prohibited}, 2'h2);
    summarize();
  end
endmodule : cgp_clock_ctl_tb
`default_nettype wire
